// [design/bhb_regs.sv]
// Purpose: Bridge header register bank, bus numbers and I/O window decode.
// Assumes: Classic Wishbone master, one request at a time, same clock.
// Notes: Each register sits in the low bits of one aligned 32-bit word.
//
// What this block does
// [RL1] Cache line size: read/write, resets zero, inert.
// [RL2] Primary latency timer reads zero, read-only.
// [RL3] Header type reads 0x01, read-only.
// [RL4] Self-test byte reads zero, read-only.
// [RL5] Both base address words read zero.
// [RL6] Upstream bus number: read/write, resets zero.
// [RL7] Downstream bus number: read/write, resets zero.
// [RL8] Highest bus number: read/write, resets zero.
// [RL9] Downstream latency timer reads zero, read-only.
// [RL10] Addressing capability bit: resets one, lockable write.
// [RL11] Limit bit 0 mirrors addressing capability.
// [RL12] I/O window decides forwarding of I/O.
// [RL13] Window fields hold A[15:12]; limit low 0xFFF.
// [RL14] Base resets 0xF, limit 0x0: window empty.
// [RL15] Read-only writes ignored; bits 3:1 read zero.
// [RL16] Base low twelve bits taken as zero.
//
// The Wishbone interface to the registers was decided locally.

`timescale 1ns/1ps

module bhb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire bhb_pkg::bhb_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire bhb_pkg::bhb_io_chk_t io_chk_i,
    output bhb_pkg::bhb_io_fwd_t io_fwd_o
);
    import bhb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic ack_r;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic [7:0] cache_line_size_r;
    logic [7:0] upstream_bus_number_r;
    logic [7:0] downstream_bus_number_r;
    logic [7:0] highest_bus_number_r;
    logic io_addressing_capability_r;
    logic [3:0] io_window_base_r;
    logic [3:0] io_window_limit_r;
    logic lock_r;
    bhb_io_fwd_t fwd_r;
    bhb_io_fwd_t fwd_nxt;

    logic acc;
    logic wr_lo;
    logic [5:0] idx;
    logic [7:0] base_byte;
    logic [7:0] limit_byte;
    logic [15:0] base_addr;
    logic [15:0] limit_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: a request is taken once, in the cycle before ack
    assign acc = wb_req_i.cyc && wb_req_i.stb && !ack_r;
    assign idx = wb_req_i.adr[7:2];
    assign wr_lo = acc && wb_req_i.we && wb_req_i.sel[0];

    // Assembled window bytes as software sees them
    assign base_byte = {io_window_base_r, 3'h0, io_addressing_capability_r}; // RL15
    assign limit_byte = {io_window_limit_r, 3'h0, io_addressing_capability_r}; // RL11

    // Window bounds, base aligned to 4 KB
    assign base_addr = {io_window_base_r, IO_BASE_LOW}; // RL16
    assign limit_addr = {io_window_limit_r, IO_LIMIT_LOW}; // RL13

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge: one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc;
        end
    end

    // Read data mux; unmapped and read-only zero words answer zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            IDX_CACHE_LINE_SIZE: rd_nxt = {24'h000000, cache_line_size_r}; // RL1
            IDX_PRIMARY_LATENCY_TIMER: rd_nxt = {24'h000000, VAL_PRIMARY_LATENCY_TIMER}; // RL2
            IDX_HEADER_TYPE: rd_nxt = {24'h000000, VAL_HEADER_TYPE}; // RL3
            IDX_SELF_TEST: rd_nxt = {24'h000000, VAL_SELF_TEST}; // RL4
            IDX_BASE_ADDRESS_ZERO: rd_nxt = VAL_BASE_ADDRESS; // RL5
            IDX_BASE_ADDRESS_ONE: rd_nxt = VAL_BASE_ADDRESS; // RL5
            IDX_UPSTREAM_BUS_NUMBER: rd_nxt = {24'h000000, upstream_bus_number_r}; // RL6
            IDX_DOWNSTREAM_BUS_NUMBER: rd_nxt = {24'h000000, downstream_bus_number_r}; // RL7
            IDX_HIGHEST_BUS_NUMBER: rd_nxt = {24'h000000, highest_bus_number_r}; // RL8
            IDX_DOWNSTREAM_LATENCY_TIMER: rd_nxt = {24'h000000, VAL_DOWNSTREAM_LATENCY_TIMER}; // RL9
            IDX_IO_WINDOW_BASE: rd_nxt = {24'h000000, base_byte}; // RL15
            IDX_IO_WINDOW_LIMIT: rd_nxt = {24'h000000, limit_byte}; // RL11
            IDX_LOCK_CTRL: rd_nxt = {31'h00000000, lock_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_r <= 32'h0000_0000;
        end else if (acc && !wb_req_i.we) begin
            rd_r <= rd_nxt;
        end else if (!acc) begin
            rd_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cache line size, stored only, never used
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cache_line_size_r <= RST_CACHE_LINE_SIZE;
        end else if (wr_lo && idx == IDX_CACHE_LINE_SIZE) begin
            cache_line_size_r <= wb_req_i.dat[7:0]; // RL1
        end
    end

    // Bus numbers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upstream_bus_number_r <= RST_BUS_NUMBER;
            downstream_bus_number_r <= RST_BUS_NUMBER;
            highest_bus_number_r <= RST_BUS_NUMBER;
        end else if (wr_lo) begin
            if (idx == IDX_UPSTREAM_BUS_NUMBER) begin
                upstream_bus_number_r <= wb_req_i.dat[7:0]; // RL6
            end
            if (idx == IDX_DOWNSTREAM_BUS_NUMBER) begin
                downstream_bus_number_r <= wb_req_i.dat[7:0]; // RL7
            end
            if (idx == IDX_HIGHEST_BUS_NUMBER) begin
                highest_bus_number_r <= wb_req_i.dat[7:0]; // RL8
            end
        end
    end

    // Register lock control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_r <= RST_LOCK;
        end else if (wr_lo && idx == IDX_LOCK_CTRL) begin
            lock_r <= wb_req_i.dat[LOCK_BIT];
        end
    end

    // Addressing capability, written only while unlocked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_addressing_capability_r <= RST_IO_CAP; // RL10
        end else if (wr_lo && idx == IDX_IO_WINDOW_BASE && !lock_r) begin
            io_addressing_capability_r <= wb_req_i.dat[IO_CAP_BIT]; // RL10
        end
    end

    // Window fields; bits 3:1 and limit bit 0 are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_window_base_r <= RST_IO_BASE; // RL14
            io_window_limit_r <= RST_IO_LIMIT; // RL14
        end else if (wr_lo) begin
            if (idx == IDX_IO_WINDOW_BASE) begin
                io_window_base_r <= wb_req_i.dat[IO_WIN_MSB:IO_WIN_LSB]; // RL13
            end
            if (idx == IDX_IO_WINDOW_LIMIT) begin
                io_window_limit_r <= wb_req_i.dat[IO_WIN_MSB:IO_WIN_LSB]; // RL13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forwarding decision; with 32-bit capability upper address must be zero
    always_comb begin
        fwd_nxt.valid = io_chk_i.valid;
        fwd_nxt.hit = io_chk_i.valid
            && (io_chk_i.addr[15:0] >= base_addr)
            && (io_chk_i.addr[15:0] <= limit_addr)
            && (!io_addressing_capability_r || io_chk_i.addr[31:16] == IO_UPPER_ZERO); // RL12
    end

    // Decision register, one cycle after the query
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_r <= '0;
        end else begin
            fwd_r <= fwd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;
    assign io_fwd_o = fwd_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Requests are answered in exactly one cycle, ack lasts one cycle
    property p_ack_timing;
        acc |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("ack not one-cycle pulse after request");

    property p_cls_rw;
        wr_lo && idx == IDX_CACHE_LINE_SIZE |=> cache_line_size_r == $past(wb_req_i.dat[7:0]);
    endproperty
    a_cls_rw: assert property (p_cls_rw) else $error("cache line size not written"); // RL1

    property p_plt_zero;
        acc && !wb_req_i.we && idx == IDX_PRIMARY_LATENCY_TIMER |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_plt_zero: assert property (p_plt_zero) else $error("primary latency timer not zero"); // RL2

    property p_hdr_type;
        acc && !wb_req_i.we && idx == IDX_HEADER_TYPE |=> wb_ack_o && wb_dat_o == 32'h0000_0001;
    endproperty
    a_hdr_type: assert property (p_hdr_type) else $error("header type not 0x01"); // RL3

    property p_self_test;
        acc && !wb_req_i.we && idx == IDX_SELF_TEST |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_self_test: assert property (p_self_test) else $error("self-test byte not zero"); // RL4

    property p_bar_zero;
        acc && !wb_req_i.we && (idx == IDX_BASE_ADDRESS_ZERO || idx == IDX_BASE_ADDRESS_ONE)
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_bar_zero: assert property (p_bar_zero) else $error("base address word not zero"); // RL5

    property p_bus_numbers;
        wr_lo && idx == IDX_UPSTREAM_BUS_NUMBER
            |=> upstream_bus_number_r == $past(wb_req_i.dat[7:0]);
    endproperty
    a_bus_numbers: assert property (p_bus_numbers) else $error("upstream bus number not written"); // RL6

    property p_down_bus;
        wr_lo && idx == IDX_DOWNSTREAM_BUS_NUMBER |=> downstream_bus_number_r == $past(wb_req_i.dat[7:0]);
    endproperty
    a_down_bus: assert property (p_down_bus) else $error("downstream bus number not written"); // RL7

    property p_high_bus;
        wr_lo && idx == IDX_HIGHEST_BUS_NUMBER |=> highest_bus_number_r == $past(wb_req_i.dat[7:0]);
    endproperty
    a_high_bus: assert property (p_high_bus) else $error("highest bus number not written"); // RL8

    property p_slt_zero;
        acc && !wb_req_i.we && idx == IDX_DOWNSTREAM_LATENCY_TIMER |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_slt_zero: assert property (p_slt_zero) else $error("downstream latency timer not zero"); // RL9

    property p_cap_locked;
        wr_lo && idx == IDX_IO_WINDOW_BASE && lock_r |=> $stable(io_addressing_capability_r);
    endproperty
    a_cap_locked: assert property (p_cap_locked) else $error("capability changed while locked"); // RL10

    property p_cap_unlocked;
        wr_lo && idx == IDX_IO_WINDOW_BASE && !lock_r
            |=> io_addressing_capability_r == $past(wb_req_i.dat[0]);
    endproperty
    a_cap_unlocked: assert property (p_cap_unlocked) else $error("capability not written when unlocked"); // RL10

    property p_limit_mirror;
        acc && !wb_req_i.we && idx == IDX_IO_WINDOW_LIMIT |=> wb_dat_o[0] == io_addressing_capability_r;
    endproperty
    a_limit_mirror: assert property (p_limit_mirror) else $error("limit bit 0 not mirroring capability"); // RL11

    property p_fwd_hit;
        io_chk_i.valid && io_chk_i.addr[31:16] == 16'h0000
            && io_chk_i.addr[15:12] >= io_window_base_r && io_chk_i.addr[15:12] <= io_window_limit_r
            |=> io_fwd_o.valid && io_fwd_o.hit;
    endproperty
    a_fwd_hit: assert property (p_fwd_hit) else $error("address in window not forwarded"); // RL12

    property p_fwd_miss;
        io_chk_i.valid && io_chk_i.addr[15:12] > io_window_limit_r |=> !io_fwd_o.hit;
    endproperty
    a_fwd_miss: assert property (p_fwd_miss) else $error("address above limit forwarded"); // RL13

    property p_reset_window;
        $fell(rst_i) |-> io_window_base_r == 4'hF && io_window_limit_r == 4'h0 && !fwd_r.hit;
    endproperty
    a_reset_window: assert property (@(posedge clk_i) p_reset_window) else $error("window not empty at reset"); // RL14

    property p_reserved_zero;
        acc && !wb_req_i.we && (idx == IDX_IO_WINDOW_BASE || idx == IDX_IO_WINDOW_LIMIT)
            |=> wb_dat_o[3:1] == 3'h0 && wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // RL15

    property p_base_align;
        io_chk_i.valid && io_chk_i.addr[31:16] == 16'h0000 && io_chk_i.addr[15:12] == io_window_base_r
            && io_window_base_r <= io_window_limit_r |=> io_fwd_o.hit;
    endproperty
    a_base_align: assert property (p_base_align) else $error("base 4 KB block not forwarded"); // RL16

    // No ack without a request taken the cycle before
    property p_ack_needs_req;
        wb_ack_o |-> $past(acc);
    endproperty
    a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

    // Read data is zero outside the ack cycle
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data not zero while idle");

    // Cache line size holds without a write to it
    property p_cls_hold;
        !(wr_lo && idx == IDX_CACHE_LINE_SIZE) |=> $stable(cache_line_size_r);
    endproperty
    a_cls_hold: assert property (p_cls_hold) else $error("cache line size changed unwritten"); // RL1

    // Upstream bus number holds without a write to it
    property p_up_hold;
        !(wr_lo && idx == IDX_UPSTREAM_BUS_NUMBER) |=> $stable(upstream_bus_number_r);
    endproperty
    a_up_hold: assert property (p_up_hold) else $error("upstream bus number changed unwritten"); // RL6

    // Downstream bus number holds without a write to it
    property p_down_hold;
        !(wr_lo && idx == IDX_DOWNSTREAM_BUS_NUMBER) |=> $stable(downstream_bus_number_r);
    endproperty
    a_down_hold: assert property (p_down_hold) else $error("downstream bus number changed unwritten"); // RL7

    // Highest bus number holds without a write to it
    property p_high_hold;
        !(wr_lo && idx == IDX_HIGHEST_BUS_NUMBER) |=> $stable(highest_bus_number_r);
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("highest bus number changed unwritten"); // RL8

    // Base field holds without a write to it
    property p_base_hold;
        !(wr_lo && idx == IDX_IO_WINDOW_BASE) |=> $stable(io_window_base_r);
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("window base changed unwritten"); // RL13

    // Limit field holds without a write to it
    property p_limit_hold;
        !(wr_lo && idx == IDX_IO_WINDOW_LIMIT) |=> $stable(io_window_limit_r);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("window limit changed unwritten"); // RL13

    // Capability bit moves only on an unlocked base write
    property p_cap_hold;
        !(wr_lo && idx == IDX_IO_WINDOW_BASE && !lock_r) |=> $stable(io_addressing_capability_r);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capability changed without write"); // RL10

    // Decision valid follows the query one cycle later
    property p_fwd_valid;
        1'b1 |=> io_fwd_o.valid == $past(io_chk_i.valid);
    endproperty
    a_fwd_valid: assert property (p_fwd_valid) else $error("decision valid not following query"); // RL12

    // No query, no forwarding
    property p_fwd_no_query;
        !io_chk_i.valid |=> !io_fwd_o.hit;
    endproperty
    a_fwd_no_query: assert property (p_fwd_no_query) else $error("forwarded without query"); // RL12

    // Base above limit leaves the window empty
    property p_empty_window;
        io_chk_i.valid && io_window_base_r > io_window_limit_r |=> !io_fwd_o.hit;
    endproperty
    a_empty_window: assert property (p_empty_window) else $error("empty window forwarded"); // RL14

    // With 32-bit addressing a nonzero upper half never forwards
    property p_cap32_upper;
        io_chk_i.valid && io_addressing_capability_r && io_chk_i.addr[31:16] != 16'h0000 |=> !io_fwd_o.hit;
    endproperty
    a_cap32_upper: assert property (p_cap32_upper) else $error("upper address forwarded"); // RL12

    // Main scenarios
    c_write_window: cover property (wr_lo && idx == IDX_IO_WINDOW_LIMIT);
    c_locked_write: cover property (wr_lo && idx == IDX_IO_WINDOW_BASE && lock_r);
    c_fwd_hit: cover property (io_fwd_o.hit);
    c_unmapped_read: cover property (acc && !wb_req_i.we && idx == 6'h11);

endmodule

// [design/bhb_pkg.sv]
// Purpose: Shared constants and carriers for the bridge header register bank.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes: Register indices are word indices; byte address is index times four.

package bhb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register word indices
    localparam logic [5:0] IDX_CACHE_LINE_SIZE = 6'h0C;
    localparam logic [5:0] IDX_PRIMARY_LATENCY_TIMER = 6'h0D;
    localparam logic [5:0] IDX_HEADER_TYPE = 6'h0E;
    localparam logic [5:0] IDX_SELF_TEST = 6'h0F;
    localparam logic [5:0] IDX_BASE_ADDRESS_ZERO = 6'h10;
    localparam logic [5:0] IDX_BASE_ADDRESS_ONE = 6'h14;
    localparam logic [5:0] IDX_UPSTREAM_BUS_NUMBER = 6'h18;
    localparam logic [5:0] IDX_DOWNSTREAM_BUS_NUMBER = 6'h19;
    localparam logic [5:0] IDX_HIGHEST_BUS_NUMBER = 6'h1A;
    localparam logic [5:0] IDX_DOWNSTREAM_LATENCY_TIMER = 6'h1B;
    localparam logic [5:0] IDX_IO_WINDOW_BASE = 6'h1C;
    localparam logic [5:0] IDX_IO_WINDOW_LIMIT = 6'h1D;
    localparam logic [5:0] IDX_LOCK_CTRL = 6'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int IO_CAP_BIT = 0;
    localparam int IO_WIN_LSB = 4;
    localparam int IO_WIN_MSB = 7;
    localparam int LOCK_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset and fixed values
    localparam logic [7:0] RST_CACHE_LINE_SIZE = 8'h00;
    localparam logic [7:0] VAL_PRIMARY_LATENCY_TIMER = 8'h00;
    localparam logic [7:0] VAL_HEADER_TYPE = 8'h01;
    localparam logic [7:0] VAL_SELF_TEST = 8'h00;
    localparam logic [31:0] VAL_BASE_ADDRESS = 32'h0000_0000;
    localparam logic [7:0] RST_BUS_NUMBER = 8'h00;
    localparam logic [7:0] VAL_DOWNSTREAM_LATENCY_TIMER = 8'h00;
    localparam logic RST_IO_CAP = 1'b1;
    localparam logic [3:0] RST_IO_BASE = 4'hF;
    localparam logic [3:0] RST_IO_LIMIT = 4'h0;
    localparam logic RST_LOCK = 1'b0;
    localparam logic [11:0] IO_BASE_LOW = 12'h000;
    localparam logic [11:0] IO_LIMIT_LOW = 12'hFFF;
    localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bhb_wb_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } bhb_io_chk_t;

    typedef struct packed {
        logic valid;
        logic hit;
    } bhb_io_fwd_t;

endpackage

// [dv/bhb_host.sv]
// Purpose: Configuration host model issuing classic Wishbone single cycles.
// Assumes: One request at a time, all signals moved right after a rising edge.
// Notes: An unanswered transfer counts as a mismatch and ends the run.

`timescale 1ns/1ps

module bhb_host (
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output bhb_pkg::bhb_wb_req_t wb_req_o
);
    import bhb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Idle bus from time zero
    initial begin
        wb_req_o = '0;
    end

    // One cycle: hold until ack, take data at that edge, then release
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        rd = '0;
        @(posedge clk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 50);
        if (wb_ack_i !== 1'b1) begin
            testbench.err_total++;
            $display("Error %0t: no ack", $time);
            testbench.summarize();
        end else begin
            rd = wb_dat_i;
            wb_req_o <= '0;
        end
    endtask
endmodule

// [dv/testbench.sv]
// Purpose: Self-checking bench for the bridge header register bank.
// Assumes: Host model drives the register bus; bench drives the I/O query.
// Notes: Table rows hold reset value, write data and read-back value.

`timescale 1ns/1ps

module testbench;
    import bhb_pkg::*;

    typedef struct {logic [7:0] adr; logic [31:0] rst; logic [31:0] wd; logic [31:0] exp;} bhb_row_t;

    logic clk_i;
    logic rst_i;
    bhb_wb_req_t wb_req;
    logic wb_ack;
    logic [31:0] wb_dat;
    bhb_io_chk_t io_chk;
    bhb_io_fwd_t io_fwd;
    logic [31:0] rd;
    int err_total = 0;
    int total_checks = 0;
    bhb_row_t rows [11] = '{
        '{8'h30, 32'h0, 32'hFFFF_FFA5, 32'h0000_00A5}, '{8'h34, 32'h0, 32'h0000_00FF, 32'h0},
        '{8'h38, 32'h1, 32'h0000_00FF, 32'h1}, '{8'h3C, 32'h0, 32'h0000_00FF, 32'h0},
        '{8'h40, 32'h0, 32'hFFFF_FFFF, 32'h0}, '{8'h50, 32'h0, 32'hFFFF_FFFF, 32'h0},
        '{8'h60, 32'h0, 32'h0000_005A, 32'h0000_005A}, '{8'h64, 32'h0, 32'h0000_00C3, 32'h0000_00C3},
        '{8'h68, 32'h0, 32'h0000_003C, 32'h0000_003C}, '{8'h6C, 32'h0, 32'h0000_00FF, 32'h0},
        '{8'h44, 32'h0, 32'h0000_00FF, 32'h0}};

    ////////////////////////////////////////////////////////////////////////////
    // Design and host
    bhb_regs dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_ack_o(wb_ack),
        .wb_dat_o(wb_dat),
        .io_chk_i(io_chk),
        .io_fwd_o(io_fwd)
    );

    bhb_host host (
        .clk_i(clk_i),
        .wb_ack_i(wb_ack),
        .wb_dat_i(wb_dat),
        .wb_req_o(wb_req)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Register write
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] dummy;
        host.xfer(1'b1, adr, d, dummy);
    endtask

    // Register read and compare
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        host.xfer(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask

    // One I/O query, decision seen one cycle later
    task automatic io_q(input logic [31:0] a, input logic hit);
        @(posedge clk_i);
        io_chk <= '{valid: 1'b1, addr: a};
        @(posedge clk_i);
        io_chk <= '0;
        #1;
        check({31'h0, io_fwd.valid}, 32'h1);
        check({31'h0, io_fwd.hit}, {31'h0, hit});
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        io_chk = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) rd_chk(rows[i].adr, rows[i].rst);
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            rd_chk(rows[i].adr, rows[i].exp);
        end
        rd_chk(8'h70, 32'h0000_00F1);
        rd_chk(8'h74, 32'h0000_0001);
        io_q(32'h0000_0000, 1'b0);
        io_q(32'h0000_F000, 1'b0);
        // Window 0x7000..0x9FFF, reserved bits written as ones
        wr(8'h70, 32'h0000_007F);
        wr(8'h74, 32'h0000_009E);
        rd_chk(8'h70, 32'h0000_0071);
        rd_chk(8'h74, 32'h0000_0091);
        io_q(32'h0000_7000, 1'b1);
        io_q(32'h0000_6FFF, 1'b0);
        io_q(32'h0000_9FFF, 1'b1);
        io_q(32'h0000_A000, 1'b0);
        io_q(32'h0001_8000, 1'b0);
        // Drop to 16-bit addressing
        wr(8'h70, 32'h0000_0070);
        rd_chk(8'h70, 32'h0000_0070);
        rd_chk(8'h74, 32'h0000_0090);
        io_q(32'h0001_8000, 1'b1);
        // Locked capability bit ignores writes
        wr(8'h80, 32'h0000_0001);
        wr(8'h70, 32'h0000_0051);
        rd_chk(8'h70, 32'h0000_0050);
        rd_chk(8'h74, 32'h0000_0090);
        // Reset in mid-run restores defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(8'h30, 32'h0);
        rd_chk(8'h68, 32'h0);
        rd_chk(8'h70, 32'h0000_00F1);
        io_q(32'h0000_F000, 1'b0);
        summarize();
    end
endmodule
